// ===== logic/tray_lift_and_jam_control.sv
// Purpose: Lifter and pickup sequencing for the add-on paper tray
// Assumes: Sensors already debounced and synchronous to core_clk_in
// Notes:   Errors hold until the host acknowledges them
`timescale 1ns/1ps
`default_nettype none
module tray_lift_and_jam_control #(
  parameter int unsigned LIFT_TIMEOUT = tray_pkg::LIFT_TIMEOUT_DEF,
  parameter int unsigned PICK_TIMEOUT = tray_pkg::PICK_TIMEOUT_DEF
) (
  input  wire logic       core_clk_in,
  input  wire logic       rstn_in,
  input  wire logic       stack_surface_sensor_in,
  input  wire logic       feed_sensor_in,
  input  wire logic       tray_door_switch_open_in,
  input  wire logic       cassette_inserted_in,
  input  wire logic       printing_in,
  input  wire logic       pick_request_in,
  input  wire logic       auto_delivery_in,
  input  wire logic       error_ack_in,
  output logic            lifter_motor_up_out,
  output logic            pickup_motor_out,
  output logic            pickup_solenoid_out,
  output logic            pick_busy_out,
  output logic            sheet_fed_out,
  output logic            lifter_fail_out,
  output logic            jam_out,
  output logic [1:0]      jam_code_out
);

  tray_timer_if lift_tmr ();
  tray_timer_if pick_tmr ();

  tray_timer #(.LIMIT(LIFT_TIMEOUT)) u_lift_timer (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .tmr         (lift_tmr.timer)
  );

  tray_timer #(.LIMIT(PICK_TIMEOUT)) u_pick_timer (
    .core_clk_in (core_clk_in),
    .rstn_in     (rstn_in),
    .tmr         (pick_tmr.timer)
  );

  tray_pkg::lift_state_t   lift_q;
  tray_pkg::lift_state_t   lift_d;
  tray_pkg::feed_state_t   feed_q;
  tray_pkg::feed_state_t   feed_d;
  tray_pkg::jam_code_t     code_q;
  tray_pkg::jam_code_t     code_d;
  logic                    poweron_q;
  logic                    poweron_d;
  logic                    cas_q;
  logic                    cas_d;
  logic                    door_q;
  logic                    door_d;
  logic                    deliv_q;
  logic                    deliv_d;
  logic                    surf_q;
  logic                    surf_d;
  logic [tray_pkg::TRY_W-1:0] tries_q;
  logic [tray_pkg::TRY_W-1:0] tries_d;
  logic                    fed_q;
  logic                    fed_d;
  logic                    lift_start;
  logic                    door_closed_evt;
  logic                    residual_evt;
  logic                    retry_pend;
  logic                    pick_take;

  // Event detection
  assign lift_start = poweron_q
                    | (cassette_inserted_in & ~cas_q)
                    | (surf_q & ~stack_surface_sensor_in & printing_in)
                    | (~stack_surface_sensor_in & cassette_inserted_in & ~printing_in
                       & surf_q);
  assign door_closed_evt = door_q & ~tray_door_switch_open_in;
  assign residual_evt = feed_sensor_in
                      & (poweron_q | door_closed_evt
                         | (auto_delivery_in & ~deliv_q));
  // Accept and retry qualifiers
  assign retry_pend = (tries_q != '0);
  assign pick_take  = pick_request_in & ~tray_door_switch_open_in & ~retry_pend;

  // Lifter sequence
  always_comb
  begin
    lift_d       = lift_q;
    lift_tmr.run = 1'b0;
    unique case (lift_q)
      tray_pkg::LIFT_IDLE:
      begin
        if (lift_start && cassette_inserted_in && !stack_surface_sensor_in)
        begin
          lift_d = tray_pkg::LIFT_RUN;
        end
      end
      tray_pkg::LIFT_RUN:
      begin
        lift_tmr.run = 1'b1;
        if (stack_surface_sensor_in || !cassette_inserted_in)
        begin
          lift_d = tray_pkg::LIFT_IDLE;
        end
        else if (lift_tmr.expired)
        begin
          lift_d = tray_pkg::LIFT_FAIL;
        end
      end
      tray_pkg::LIFT_FAIL:
      begin
        if (error_ack_in)
        begin
          lift_d = tray_pkg::LIFT_IDLE;
        end
      end
      default:
      begin
        lift_d = tray_pkg::LIFT_IDLE;
      end
    endcase
  end

  // Pickup and jam sequence
  always_comb
  begin
    feed_d       = feed_q;
    code_d       = code_q;
    tries_d      = tries_q;
    fed_d        = 1'b0;
    pick_tmr.run = 1'b0;
    unique case (feed_q)
      tray_pkg::FEED_IDLE:
      begin
        if (residual_evt)
        begin
          feed_d = tray_pkg::FEED_JAM;
          code_d = tray_pkg::JAM_RESIDUAL;
        end
        else if (pick_take)
        begin
          feed_d  = tray_pkg::FEED_PICK;
          tries_d = '0;
        end
      end
      tray_pkg::FEED_PICK:
      begin
        pick_tmr.run = 1'b1;
        if (tray_door_switch_open_in)
        begin
          feed_d = tray_pkg::FEED_JAM;
          code_d = tray_pkg::JAM_DOOR;
        end
        else if (feed_sensor_in)
        begin
          feed_d = tray_pkg::FEED_PASS;
        end
        else if (pick_tmr.expired)
        begin
          if (tries_q == tray_pkg::TRY_W'(tray_pkg::PICK_TRIES - 1))
          begin
            feed_d = tray_pkg::FEED_JAM;
            code_d = tray_pkg::JAM_DELAY;
          end
          else
          begin
            feed_d  = tray_pkg::FEED_IDLE;
            tries_d = tries_q + 1'b1;
          end
        end
      end
      tray_pkg::FEED_PASS:
      begin
        if (tray_door_switch_open_in)
        begin
          feed_d = tray_pkg::FEED_JAM;
          code_d = tray_pkg::JAM_DOOR;
        end
        else if (!feed_sensor_in)
        begin
          feed_d = tray_pkg::FEED_IDLE;
          fed_d  = 1'b1;
        end
      end
      tray_pkg::FEED_JAM:
      begin
        if (error_ack_in)
        begin
          feed_d = tray_pkg::FEED_IDLE;
          code_d = tray_pkg::JAM_NONE;
        end
      end
      default:
      begin
        feed_d = tray_pkg::FEED_IDLE;
      end
    endcase
    // Retry: one idle cycle then re-energise the solenoid
    if (feed_q == tray_pkg::FEED_IDLE && retry_pend && !residual_evt
        && !tray_door_switch_open_in)
    begin
      feed_d = tray_pkg::FEED_PICK;
    end
    if (feed_q == tray_pkg::FEED_IDLE && retry_pend && tray_door_switch_open_in)
    begin
      feed_d  = tray_pkg::FEED_JAM;
      code_d  = tray_pkg::JAM_DOOR;
      tries_d = '0;
    end
    if (feed_d == tray_pkg::FEED_PASS || feed_d == tray_pkg::FEED_JAM)
    begin
      tries_d = '0;
    end
  end

  // Edge history
  always_comb
  begin
    poweron_d = 1'b0;
    cas_d     = cassette_inserted_in;
    door_d    = tray_door_switch_open_in;
    deliv_d   = auto_delivery_in;
    surf_d    = stack_surface_sensor_in;
  end

  // Lifter state register
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      lift_q <= tray_pkg::LIFT_IDLE;
    end
    else
    begin
      lift_q <= lift_d;
    end
  end

  // Feed state registers
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      feed_q  <= tray_pkg::FEED_IDLE;
      code_q  <= tray_pkg::JAM_NONE;
      tries_q <= '0;
      fed_q   <= 1'b0;
    end
    else
    begin
      feed_q  <= feed_d;
      code_q  <= code_d;
      tries_q <= tries_d;
      fed_q   <= fed_d;
    end
  end

  // Edge history registers
  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      poweron_q <= 1'b1;
      cas_q     <= 1'b0;
      door_q    <= 1'b0;
      deliv_q   <= 1'b0;
      surf_q    <= 1'b1;
    end
    else
    begin
      poweron_q <= poweron_d;
      cas_q     <= cas_d;
      door_q    <= door_d;
      deliv_q   <= deliv_d;
      surf_q    <= surf_d;
    end
  end

  // Separate pickup and lifter drives
  assign lifter_motor_up_out = (lift_q == tray_pkg::LIFT_RUN);
  assign pickup_motor_out    = (feed_q == tray_pkg::FEED_PICK)
                             | (feed_q == tray_pkg::FEED_PASS);
  assign pickup_solenoid_out = (feed_q == tray_pkg::FEED_PICK);
  assign pick_busy_out       = (feed_q != tray_pkg::FEED_IDLE) | retry_pend;
  assign sheet_fed_out       = fed_q;
  assign lifter_fail_out     = (lift_q == tray_pkg::LIFT_FAIL);
  assign jam_out             = (feed_q == tray_pkg::FEED_JAM);
  assign jam_code_out        = code_q;

endmodule : tray_lift_and_jam_control
`default_nettype wire

// ===== logic/tray_pkg.sv
// Purpose: Shared constants and types for the add-on tray lift and feed sequencer
// Assumes: One 20 MHz clock, synchronous active-low reset
// Notes:   Timeout lengths are parameters of the top module
package tray_pkg;

  localparam int unsigned CLK_HZ            = 20000000;
  localparam int unsigned CNT_W             = 32;
  localparam int unsigned LIFT_TIMEOUT_DEF  = 32'h0001_0000;
  localparam int unsigned PICK_TIMEOUT_DEF  = 32'h0000_8000;
  localparam int unsigned PICK_TRIES        = 2;
  localparam int unsigned TRY_W             = 2;

  typedef enum logic [1:0] {
    LIFT_IDLE  = 2'b00,
    LIFT_RUN   = 2'b01,
    LIFT_FAIL  = 2'b10
  } lift_state_t;

  typedef enum logic [2:0] {
    FEED_IDLE  = 3'b000,
    FEED_PICK  = 3'b001,
    FEED_PASS  = 3'b010,
    FEED_JAM   = 3'b011
  } feed_state_t;

  typedef enum logic [1:0] {
    JAM_NONE     = 2'b00,
    JAM_DELAY    = 2'b01,
    JAM_RESIDUAL = 2'b10,
    JAM_DOOR     = 2'b11
  } jam_code_t;

endpackage : tray_pkg

// ===== logic/tray_timer.sv
// Purpose: Clock-cycle timeout counter
// Assumes: Run held high for the whole timed interval
// Notes:   Clears whenever run drops
`timescale 1ns/1ps
`default_nettype none
module tray_timer #(
  parameter int unsigned LIMIT = tray_pkg::PICK_TIMEOUT_DEF
) (
  input  wire logic     core_clk_in,
  input  wire logic     rstn_in,
  tray_timer_if.timer   tmr
);

  logic [tray_pkg::CNT_W-1:0] count_q;
  logic [tray_pkg::CNT_W-1:0] count_d;
  logic                       exp_q;
  logic                       exp_d;

  // Terminal count is a parameter
  always_comb
  begin
    count_d = '0;
    exp_d   = 1'b0;
    if (tmr.run)
    begin
      if (count_q >= tray_pkg::CNT_W'(LIMIT - 1))
      begin
        count_d = count_q;
        exp_d   = 1'b1;
      end
      else
      begin
        count_d = count_q + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rstn_in)
    begin
      count_q <= '0;
      exp_q   <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      exp_q   <= exp_d;
    end
  end

  assign tmr.expired = exp_q & tmr.run;

endmodule : tray_timer
`default_nettype wire

// ===== logic/tray_timer_if.sv
// Purpose: Carries start and expiry of one timeout counter
// Assumes: Single clock domain
// Notes:   Used between the sequencer and its timers
`timescale 1ns/1ps
`default_nettype none
interface tray_timer_if;
  logic run;
  logic expired;
  modport ctrl  (output run, input expired);
  modport timer (input run, output expired);
endinterface : tray_timer_if
`default_nettype wire

// ===== verif/tray_lift_and_jam_control_asserts.sv
// Purpose: Port checks for the tray sequencer
// Assumes: One clock, sync reset
// Notes:   Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module tray_lift_and_jam_control_asserts #(
  parameter int unsigned LIFT_TIMEOUT = 8,
  parameter int unsigned PICK_TIMEOUT = 8
) (
  input wire logic       core_clk_in,
  input wire logic       rstn_in,
  input wire logic       stack_surface_sensor_in,
  input wire logic       feed_sensor_in,
  input wire logic       tray_door_switch_open_in,
  input wire logic       cassette_inserted_in,
  input wire logic       pick_request_in,
  input wire logic       error_ack_in,
  input wire logic       lifter_motor_up_out,
  input wire logic       pickup_motor_out,
  input wire logic       pickup_solenoid_out,
  input wire logic       pick_busy_out,
  input wire logic       sheet_fed_out,
  input wire logic       lifter_fail_out,
  input wire logic       jam_out,
  input wire logic [1:0] jam_code_out
);
  logic [31:0] lift_run_q;
  logic [31:0] sol_run_q;
  // Run lengths of lifter and solenoid
  always_ff @(posedge core_clk_in)
  begin
    lift_run_q <= (!rstn_in || !lifter_motor_up_out) ? 32'h0 : lift_run_q + 32'h1;
    sol_run_q  <= (!rstn_in || !pickup_solenoid_out) ? 32'h0 : sol_run_q + 32'h1;
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  a_lift_on_drop: assert property (
    $fell(stack_surface_sensor_in) && cassette_inserted_in && !lifter_motor_up_out
    && !lifter_fail_out |=> lifter_motor_up_out) else $error("no lift");
  a_lift_stop_surface: assert property (
    lifter_motor_up_out && stack_surface_sensor_in |=> !lifter_motor_up_out)
    else $error("lifter ran on");
  a_lift_run_bound: assert property (lift_run_q <= LIFT_TIMEOUT + 2)
    else $error("lifter past timeout");
  a_fail_after_lift: assert property (
    $rose(lifter_fail_out) |-> $past(lifter_motor_up_out)) else $error("fail without lift");
  a_pick_taken: assert property (
    pick_request_in && !pick_busy_out && !tray_door_switch_open_in && !feed_sensor_in
    && !jam_out |=> pickup_solenoid_out && pickup_motor_out && pick_busy_out)
    else $error("pick not taken");
  a_sol_drop_edge: assert property (
    pickup_solenoid_out && feed_sensor_in |=> !pickup_solenoid_out) else $error("solenoid held");
  a_sol_run_bound: assert property (sol_run_q <= PICK_TIMEOUT + 2)
    else $error("solenoid past timeout");
  a_fed_one_pulse: assert property (
    sheet_fed_out |-> ($past(pickup_motor_out) && !pickup_motor_out) ##1 !sheet_fed_out)
    else $error("bad fed pulse");
  a_door_open_jam: assert property (
    tray_door_switch_open_in && pick_busy_out && !jam_out
    |=> jam_out && jam_code_out == tray_pkg::JAM_DOOR) else $error("no door jam");
  a_jam_held: assert property (
    jam_out && !error_ack_in |=> jam_out && $stable(jam_code_out)) else $error("jam dropped");
  c_fed: cover property (sheet_fed_out);
  c_delay_jam: cover property (jam_out && jam_code_out == tray_pkg::JAM_DELAY);
  c_lift_fail: cover property ($rose(lifter_fail_out));
endmodule : tray_lift_and_jam_control_asserts
bind tray_lift_and_jam_control tray_lift_and_jam_control_asserts #(.LIFT_TIMEOUT(LIFT_TIMEOUT),
  .PICK_TIMEOUT(PICK_TIMEOUT)) i_tray_lift_and_jam_control_asserts (.*);
`default_nettype wire

// ===== verif/tray_lift_and_jam_control_tb_top.sv
// Purpose: Self-checking bench for the tray sequencer
// Assumes: Short timeouts
// Notes:   Events are checked against a queue
`timescale 1ns/1ps
`default_nettype none
module tray_lift_and_jam_control_tb_top;
  localparam int unsigned LT = 8;
  logic clk, rstn, door, cas, prn, req, auto_d, ack, paper, drop;
  logic feed_m, surf, up, mot, sol, busy, fed, fail, jam, jam_q, fail_q, sol_q;
  logic [2:0] want, seen;
  logic [1:0] code;
  logic [3:0] plat, llat;
  logic [2:0] expq[$];
  logic [31:0] lfsr;
  int bad_count, cmp_count, cyc, sol_rises, sol_base;
  tray_lift_and_jam_control #(.LIFT_TIMEOUT(LT), .PICK_TIMEOUT(8)) i_tray_lift_and_jam_control (
    .core_clk_in(clk), .rstn_in(rstn), .stack_surface_sensor_in(surf),
    .feed_sensor_in(feed_m | paper), .tray_door_switch_open_in(door), .cassette_inserted_in(cas),
    .printing_in(prn), .pick_request_in(req), .auto_delivery_in(auto_d), .error_ack_in(ack),
    .lifter_motor_up_out(up), .pickup_motor_out(mot), .pickup_solenoid_out(sol),
    .pick_busy_out(busy), .sheet_fed_out(fed), .lifter_fail_out(fail), .jam_out(jam),
    .jam_code_out(code));
  tray_path_model i_tray_path_model (.clk_in(clk), .motor_in(mot), .sol_in(sol), .lift_in(up),
    .drop_in(drop), .pick_lat_in(plat), .lift_lat_in(llat), .feed_out(feed_m), .surf_out(surf));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic check(input string what, input logic [2:0] exp, input logic [2:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step
  task automatic pick;
    req = 1'b1;
    step(1);
    req = 1'b0;
  endtask : pick
  task automatic clear;
    ack = 1'b1;
    step(1);
    ack = 1'b0;
    step(1);
  endtask : clear
  // Result watcher takes the oldest expectation
  always @(negedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      summarize();
    end
    else
    begin
      if (rstn && (fed === 1'b1 || (jam === 1'b1 && jam_q !== 1'b1)
          || (fail === 1'b1 && fail_q !== 1'b1)))
      begin
        seen = fed ? 3'h0 : fail ? 3'h4 : {1'b0, code};
        want = expq.size() > 0 ? expq.pop_front() : 3'h7;
        check("event", want, seen);
      end
      if (sol === 1'b1 && sol_q !== 1'b1)
        sol_rises++;
      jam_q <= jam;
      fail_q <= fail;
      sol_q <= sol;
    end
  end
  initial
  begin
    {rstn, door, prn, req, auto_d, ack, paper, drop} = '0;
    cas = 1'b1;
    plat = 4'h3;
    llat = 4'h4;
    lfsr = 32'h6e9ed0df;
    step(4);
    rstn = 1'b1;
    step(3);
    check("lift at power on", 3'h1, {2'h0, up});
    step(8);
    check("lift stopped", 3'h0, {2'h0, up});
    for (int i = 0; i < 4; i++)
    begin
      lfsr = lfsr_next(lfsr);
      plat = {1'b0, lfsr[2:0]} | 4'h1;
      prn = lfsr[3];
      ack = lfsr[4];
      expq.push_back(3'h0);
      pick();
      check("lifter idle in pick", 3'h0, {2'h0, up});
      for (int k = 0; k < 100 && busy !== 1'b0; k++)
        step(1);
    end
    prn = 1'b0;
    ack = 1'b0;
    plat = 4'h0;
    sol_base = sol_rises;
    expq.push_back(3'h1);
    pick();
    step(30);
    check("pick tries", 3'(tray_pkg::PICK_TRIES), 3'(sol_rises - sol_base));
    clear();
    plat = 4'h7;
    expq.push_back(3'h3);
    pick();
    step(2);
    door = 1'b1;
    step(2);
    door = 1'b0;
    step(2);
    clear();
    paper = 1'b1;
    expq.push_back(3'h2);
    auto_d = 1'b1;
    step(1);
    auto_d = 1'b0;
    step(3);
    clear();
    door = 1'b1;
    step(2);
    expq.push_back(3'h2);
    door = 1'b0;
    step(3);
    clear();
    paper = 1'b0;
    prn = 1'b1;
    drop = 1'b1;
    step(1);
    drop = 1'b0;
    step(3);
    check("relift in print", 3'h1, {2'h0, up});
    step(8);
    llat = 4'h0;
    drop = 1'b1;
    expq.push_back(3'h4);
    step(1);
    drop = 1'b0;
    step(LT + 10);
    cas = 1'b0;
    clear();
    llat = 4'h4;
    step(2);
    check("no lift without cassette", 3'h0, {2'h0, up});
    cas = 1'b1;
    step(3);
    check("lift on insertion", 3'h1, {2'h0, up});
    step(10);
    check("all events seen", 3'h0, expq.size() > 0 ? 3'h1 : 3'h0);
    summarize();
  end
endmodule : tray_lift_and_jam_control_tb_top
`default_nettype wire

// ===== verif/tray_path_model.sv
// Purpose: Paper path and lifter plate model
// Assumes: Latency 0 means the event never comes
// Notes:   Sheet needs motor and solenoid
`timescale 1ns/1ps
`default_nettype none
module tray_path_model (
  input  wire logic       clk_in,
  input  wire logic       motor_in,
  input  wire logic       sol_in,
  input  wire logic       lift_in,
  input  wire logic       drop_in,
  input  wire logic [3:0] pick_lat_in,
  input  wire logic [3:0] lift_lat_in,
  output logic            feed_out,
  output logic            surf_out
);
  logic [3:0] pick_cnt_q;
  logic [3:0] lift_cnt_q;
  logic [3:0] hold_q;
  initial
  begin
    {pick_cnt_q, lift_cnt_q, hold_q, feed_out, surf_out} = '0;
  end
  always @(posedge clk_in)
  begin
    pick_cnt_q <= sol_in ? pick_cnt_q + 4'h1 : 4'h0;
    lift_cnt_q <= lift_in ? lift_cnt_q + 4'h1 : 4'h0;
    // Sheet covers the sensor, then moves on to the engine
    if (sol_in && motor_in && pick_lat_in != 4'h0 && pick_cnt_q == pick_lat_in)
      hold_q <= 4'h3;
    else if (hold_q != 4'h0 && motor_in)
      hold_q <= hold_q - 4'h1;
    feed_out <= hold_q != 4'h0;
    if (drop_in)
      surf_out <= 1'b0;
    else if (lift_in && lift_lat_in != 4'h0 && lift_cnt_q == lift_lat_in)
      surf_out <= 1'b1;
  end
endmodule : tray_path_model
`default_nettype wire
